/* File: logic/por_bootstrap.sv */
/*
  Power-on reset sequencer with strap capture and host pin muxing.
  Assumes all pin inputs are already synchronous to clk; pad drivers and
  pull resistors are outside.
*/
// How it works
// R01: A low on the reset pin holds the whole block in reset.
// R02: The board must reset the device after every power-up.
// R03: The board should hold reset low 2 ms after supplies are stable.
// R04: Registers count as reachable 125 ms after reset rises unless ready.
// R05: Bit 7 of register zero reads high once registers are reachable.
// R06: The level on the mode strap pin chooses I2C or SPI host mode.
// R07: General pins 1 and 0 choose the master clock rate.
// R08: The board sets straps 0, 1, 3 by pulls or by driving for 125 ms.
// R09: The board holds the must-be-low pin low during reset.
// R10: General pins 5 and 6 are never sampled for configuration.
// R11: After configuration general pins carry status and control functions.
// R12: The host clock pin clocks SPI and is the I2C clock in I2C mode.
// R13: In SPI mode the chip select is active low.
// R14: In I2C mode the serial out pin is an address select input.
// R15: Straps are captured once after reset release and held until reset.
`timescale 1ns/1ps
module por_bootstrap
#(
  parameter int unsigned READY_CYC = por_pkg::READY_DELAY_CYC
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic por_reset_n,
  input wire logic [por_pkg::GPIO_W-1:0] gpio_in,
  input wire logic [por_pkg::GPIO_W-1:0] gpio_func_out,
  input wire logic [por_pkg::GPIO_W-1:0] gpio_func_oe,
  input wire logic host_clk_pin,
  input wire logic host_select_n_addr_sel0,
  input wire logic host_serial_out_addr_sel1_in,
  input wire logic host_read_data,
  input wire logic host_read_data_oe,
  output logic [por_pkg::GPIO_W-1:0] gpio_out,
  output logic [por_pkg::GPIO_W-1:0] gpio_oe,
  output logic host_serial_out_addr_sel1_out,
  output logic host_serial_out_addr_sel1_oe,
  output logic dev_reset,
  output logic regs_ready,
  output logic [7:0] status_reg0,
  output logic host_mode_i2c,
  output logic [1:0] clock_rate_sel,
  output logic strap_low_error,
  output logic spi_select,
  output logic spi_clk,
  output logic i2c_scl,
  output logic [1:0] i2c_addr_sel
);
  import por_pkg::*;

  por_state_t state_reg, state_next;
  // Wide enough for the full 125 ms count at 100 MHz
  logic [31:0] cnt_reg, cnt_next;
  logic mode_reg, mode_next;
  logic [1:0] rate_reg, rate_next;
  logic low_err_reg, low_err_next;
  logic [GPIO_W-1:0] out_reg, out_next;
  logic [GPIO_W-1:0] oe_reg, oe_next;
  logic so_reg, so_next;
  logic so_oe_reg, so_oe_next;
  logic sel_reg, sel_next;
  logic sclk_reg, sclk_next;
  logic scl_reg, scl_next;
  logic [1:0] asel_reg, asel_next;
  logic rst_all;
  logic ready;

  assign rst_all = rst || !por_reset_n; // R01
  assign ready = (state_reg == por_st_ready);

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    mode_next = mode_reg;
    rate_next = rate_reg;
    low_err_next = low_err_reg;
    case (state_reg)
      por_st_reset:
      begin
        cnt_next = '0;
        state_next = por_st_settle;
      end
      por_st_settle:
      begin
        // Short settle lets strap pads recover after reset rises
        if (cnt_reg >= STRAP_SETTLE_CYC - 1)
        begin
          // Pins 5 and 6 deliberately left out of the capture
          mode_next = gpio_in[PIN_MODE]; // R06 R10 R15
          rate_next = {gpio_in[PIN_RATE1], gpio_in[PIN_RATE0]}; // R07 R15
          low_err_next = gpio_in[PIN_LOW]; // R09 R15
          cnt_next = '0;
          state_next = por_st_wait;
        end
        else
        begin
          cnt_next = cnt_reg + 32'h1;
        end
      end
      por_st_wait:
      begin
        if (cnt_reg >= READY_CYC - 1)
        begin
          state_next = por_st_ready; // R04
        end
        else
        begin
          cnt_next = cnt_reg + 32'h1;
        end
      end
      default:
      begin
        state_next = por_st_ready;
      end
    endcase
  end

  always_comb
  begin
    // Pins stay inputs until ready so board strap drive never collides
    out_next = ready ? gpio_func_out : '0; // R08 R11
    oe_next = ready ? gpio_func_oe : GPIO_OE_RST; // R11
    sclk_next = host_clk_pin; // R12
    scl_next = mode_reg ? host_clk_pin : 1'h1; // R12
    sel_next = !mode_reg && !host_select_n_addr_sel0; // R13
    asel_next = mode_reg ? {host_serial_out_addr_sel1_in,
                            host_select_n_addr_sel0} : 2'h0; // R14
    so_next = mode_reg ? 1'h0 : host_read_data;
    so_oe_next = !mode_reg && ready && host_read_data_oe; // R14
  end

  always_ff @(posedge clk)
  begin
    if (rst_all)
    begin
      state_reg <= por_st_reset;
      cnt_reg <= '0;
      mode_reg <= MODE_RST;
      rate_reg <= RATE_RST;
      low_err_reg <= 1'h0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      mode_reg <= mode_next;
      rate_reg <= rate_next;
      low_err_reg <= low_err_next;
    end
  end

  // Pin mux group kept apart from the sequencer state
  always_ff @(posedge clk)
  begin
    if (rst_all)
    begin
      out_reg <= '0;
      oe_reg <= GPIO_OE_RST;
      so_reg <= 1'h0;
      so_oe_reg <= 1'h0;
      sel_reg <= 1'h0;
      sclk_reg <= 1'h0;
      scl_reg <= 1'h1;
      asel_reg <= 2'h0;
    end
    else
    begin
      out_reg <= out_next;
      oe_reg <= oe_next;
      so_reg <= so_next;
      so_oe_reg <= so_oe_next;
      sel_reg <= sel_next;
      sclk_reg <= sclk_next;
      scl_reg <= scl_next;
      asel_reg <= asel_next;
    end
  end

  // Ready flag and status word share one register stage
  logic dev_reset_reg;
  logic ready_reg;
  logic [7:0] status_next;
  logic [7:0] status_q;
  always_comb
  begin
    status_next = '0;
    status_next[READY_BIT] = ready; // R05
  end
  always_ff @(posedge clk)
  begin
    if (rst_all)
    begin
      dev_reset_reg <= 1'h1; // R01
      ready_reg <= 1'h0;
      status_q <= 8'h00;
    end
    else
    begin
      dev_reset_reg <= 1'h0;
      ready_reg <= ready; // R04
      status_q <= status_next;
    end
  end

  assign dev_reset = dev_reset_reg;
  assign regs_ready = ready_reg;
  assign status_reg0 = status_q;
  assign host_mode_i2c = mode_reg;
  assign clock_rate_sel = rate_reg;
  assign strap_low_error = low_err_reg;
  assign gpio_out = out_reg;
  assign gpio_oe = oe_reg;
  assign host_serial_out_addr_sel1_out = so_reg;
  assign host_serial_out_addr_sel1_oe = so_oe_reg;
  assign spi_select = sel_reg;
  assign spi_clk = sclk_reg;
  assign i2c_scl = scl_reg;
  assign i2c_addr_sel = asel_reg;
endmodule : por_bootstrap

/* File: logic/por_pkg.sv */
/*
  Package for the power-on reset and strap capture block: timing counts,
  strap pin positions and mode encodings.
  Assumes a 100 MHz system clock.
*/
package por_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned READY_DELAY_MS = 125;
  localparam int unsigned READY_DELAY_CYC = READY_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned STRAP_SETTLE_CYC = 2;
  localparam int GPIO_W = 7;
  localparam int PIN_RATE0 = 0;
  localparam int PIN_RATE1 = 1;
  localparam int PIN_MODE = 3;
  localparam int PIN_LOW = 4;
  localparam int READY_BIT = 7;
  localparam logic MODE_RST = 1'h0;
  localparam logic [1:0] RATE_RST = 2'h0;
  localparam logic [GPIO_W-1:0] GPIO_OE_RST = 7'h00;
  typedef enum logic {
    por_host_spi,
    por_host_i2c
  } por_host_t;
  typedef enum logic [1:0] {
    por_st_reset,
    por_st_settle,
    por_st_wait,
    por_st_ready
  } por_state_t;
endpackage : por_pkg

/* File: sim/por_board_model.sv */
/* Board controller: reset pulse and strap drive on pins 4:0.
   Assumes go is a one-cycle request from the bench. */
`timescale 1ns/1ps
module por_board_model
#(
  parameter int LOW_CYC = 20,
  parameter int HOLD_CYC = 20
)
(
  input wire logic clk,
  input wire logic go,
  input wire logic [4:0] strap,
  output logic por_reset_n,
  output logic [4:0] pin_lvl
);
  int n = 0;
  always @(posedge clk)
    n <= go ? 1 : (n != 0 ? n + 1 : 0);
  // Every start resets; short low time stands in for 2 ms
  assign por_reset_n = !(n != 0 && n <= LOW_CYC);
  // Released pins fall to the pull-down level
  // Straps released HOLD_CYC cycles after reset rises, before pins are driven
  assign pin_lvl = (n != 0 && n <= LOW_CYC + HOLD_CYC) ?
    strap : 5'h00;
endmodule : por_board_model

/* File: sim/por_bootstrap_chk.sv */
/* Checker for por_bootstrap ports.
   Assumes binding to every por_bootstrap instance. */
`timescale 1ns/1ps
module por_bootstrap_chk
#(
  parameter int unsigned READY_CYC = 20
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic por_reset_n,
  input wire logic [6:0] gpio_in,
  input wire logic [6:0] gpio_func_oe,
  input wire logic host_clk_pin,
  input wire logic host_select_n_addr_sel0,
  input wire logic host_serial_out_addr_sel1_in,
  input wire logic [6:0] gpio_oe,
  input wire logic host_serial_out_addr_sel1_oe,
  input wire logic dev_reset,
  input wire logic regs_ready,
  input wire logic [7:0] status_reg0,
  input wire logic host_mode_i2c,
  input wire logic [1:0] clock_rate_sel,
  input wire logic strap_low_error,
  input wire logic spi_select,
  input wire logic i2c_scl,
  input wire logic [1:0] i2c_addr_sel
);
  int unsigned cnt;
  // Cycles since release, saturating
  always_ff @(posedge clk)
    cnt <= (rst || !por_reset_n) ? 0 : (cnt < 1000 ? cnt + 1 : cnt);
  default clocking @(posedge clk); endclocking
  default disable iff (rst || !por_reset_n);
  sequence s_set;
    cnt > 9;
  endsequence
  sequence s_take;
    cnt == 2;
  endsequence
  a_strap_take: assert property (s_take |=>
    host_mode_i2c == $past(gpio_in[3]) &&
    clock_rate_sel == $past(gpio_in[1:0]) &&
    strap_low_error == $past(gpio_in[4])) else $error("strap capture");
  a_reset_holds: assert property (disable iff (1'b0) !por_reset_n |=>
    dev_reset && !regs_ready) else $error("reset not held");
  a_ready_early: assert property (regs_ready |-> cnt >= READY_CYC)
    else $error("ready too early");
  a_ready_late: assert property (cnt == READY_CYC + 8 |-> regs_ready)
    else $error("ready too late");
  a_ready_bit: assert property (status_reg0 == {regs_ready, 7'h00})
    else $error("status bit wrong");
  a_gpio_quiet: assert property (!regs_ready |-> gpio_oe == 7'h00)
    else $error("gpio driven early");
  a_gpio_func: assert property (regs_ready |=>
    gpio_oe == $past(gpio_func_oe)) else $error("gpio enable lost");
  a_strap_hold: assert property (s_set |-> $stable(host_mode_i2c) &&
    $stable(clock_rate_sel)) else $error("strap moved");
  a_spi_sel: assert property (s_set ##0 !host_mode_i2c |=>
    spi_select == !$past(host_select_n_addr_sel0)) else $error("select");
  a_scl_mux: assert property (s_set |=> i2c_scl ==
    ($past(host_mode_i2c) ? $past(host_clk_pin) : 1'b1)) else $error("scl");
  a_addr_sel: assert property (s_set ##0 host_mode_i2c |=>
    i2c_addr_sel == {$past(host_serial_out_addr_sel1_in),
    $past(host_select_n_addr_sel0)} && !host_serial_out_addr_sel1_oe)
    else $error("addr sel");
endmodule : por_bootstrap_chk
bind por_bootstrap por_bootstrap_chk #(.READY_CYC(READY_CYC)) u_chk (.clk,
  .rst, .por_reset_n, .gpio_in, .gpio_func_oe, .host_clk_pin,
  .host_select_n_addr_sel0, .host_serial_out_addr_sel1_in, .gpio_oe,
  .host_serial_out_addr_sel1_oe, .dev_reset, .regs_ready, .status_reg0,
  .host_mode_i2c, .clock_rate_sel, .strap_low_error, .spi_select, .i2c_scl,
  .i2c_addr_sel);

/* File: sim/por_bootstrap_tb.sv */
/* Testbench for por_bootstrap with board model and checker.
   Assumes the checker is bound in. */
`timescale 1ns/1ps
module por_bootstrap_tb;
  import por_pkg::*;
  logic clk = 0, rst = 1, go = 0, host_clk_pin = 0, host_read_data = 0;
  logic host_select_n_addr_sel0 = 1, host_serial_out_addr_sel1_in = 0;
  logic host_read_data_oe = 0, dev_reset, regs_ready, host_mode_i2c;
  logic host_serial_out_addr_sel1_out, host_serial_out_addr_sel1_oe;
  logic strap_low_error, spi_select, spi_clk, i2c_scl, por_reset_n;
  logic [4:0] strap = 0, pin_lvl;
  logic [1:0] hi56 = 0, clock_rate_sel, i2c_addr_sel;
  logic [6:0] gpio_func_out = 7'h5a, gpio_func_oe = 7'h3c, gpio_out, gpio_oe;
  logic [7:0] status_reg0;
  wire logic [6:0] gpio_in = {hi56, pin_lvl};
  int error_cnt = 0, checked = 0, cyc = 0;
  por_board_model u_por_board_model (.clk, .go, .strap, .por_reset_n,
    .pin_lvl);
  por_bootstrap #(.READY_CYC(20)) u_por_bootstrap (.clk, .rst, .por_reset_n,
    .gpio_in, .gpio_func_out, .gpio_func_oe, .host_clk_pin,
    .host_select_n_addr_sel0, .host_serial_out_addr_sel1_in, .host_read_data,
    .host_read_data_oe, .gpio_out, .gpio_oe, .host_serial_out_addr_sel1_out,
    .host_serial_out_addr_sel1_oe, .dev_reset, .regs_ready, .status_reg0,
    .host_mode_i2c, .clock_rate_sel, .strap_low_error, .spi_select, .spi_clk,
    .i2c_scl, .i2c_addr_sel);
  always #5 clk = !clk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic boot(input logic [4:0] s, input logic [1:0] h);
    int w = 0;
    strap = s;
    hi56 = h;
    go = 1;
    @(negedge clk);
    go = 0;
    repeat (3) @(negedge clk);
    chk({dev_reset, regs_ready}, 8'h2);
    while (regs_ready !== 1'b1 && w < 200)
    begin
      @(negedge clk);
      w++;
    end
    chk(w >= 37 && w < 60, 1);
    chk(status_reg0, 8'h80);
    chk({strap_low_error, host_mode_i2c}, s[4:3]);
    chk(clock_rate_sel, s[1:0]);
    @(negedge clk);
    chk({gpio_oe, 1'b0}, {gpio_func_oe, 1'b0});
    chk({1'b0, gpio_out}, {1'b0, gpio_func_out});
  endtask : boot
  task automatic host_t(input logic m);
    host_clk_pin = 0;
    host_select_n_addr_sel0 = m;
    host_serial_out_addr_sel1_in = !m;
    host_read_data_oe = 1;
    host_read_data = 1;
    repeat (2) @(negedge clk);
    chk({spi_select, host_serial_out_addr_sel1_oe}, {!m, !m});
    chk({i2c_scl, spi_clk}, {!m, 1'b0});
    chk(host_serial_out_addr_sel1_out, !m);
    chk(i2c_addr_sel, m ? 2'h1 : 2'h0);
    host_clk_pin = 1;
    repeat (2) @(negedge clk);
    chk({i2c_scl, spi_clk}, 8'h03);
    host_clk_pin = 0;
  endtask : host_t
  task automatic report_and_stop;
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  // Ceiling well above nine boots of about fifty cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial
  begin
    repeat (10) @(negedge clk);
    rst = 0;
    for (int i = 0; i < 8; i++)
    begin
      boot({1'b0, i[2], 1'b0, i[1:0]}, i[1:0]);
      host_t(i[2]);
    end
    boot(5'h10, 2'h3);
    report_and_stop();
  end
endmodule : por_bootstrap_tb
